// File: src/csrb_cal_mem.v
`timescale 1ns/1ps
`include "csrb_defs.vh"

module csrb_cal_mem (
    // clock and reset
    input wire i_clk,
    input wire i_arst_n,
    // write port
    input wire i_wr,
    input wire [1:0] i_waddr,
    input wire [7:0] i_wdata,
    // read port
    input wire [1:0] i_raddr,
    output reg [7:0] o_rdata
);

    reg [7:0] mem_q [0:`CSRB_CAL_WORDS-1];
    integer k;

    // factory values come back on every reset, never zero
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            mem_q[0] <= `CSRB_CAL_FACTORY_0;
            mem_q[1] <= `CSRB_CAL_FACTORY_1;
            mem_q[2] <= `CSRB_CAL_FACTORY_2;
            mem_q[3] <= `CSRB_CAL_FACTORY_3;
            o_rdata <= 8'h00;
        end else begin
            for (k = 0; k < `CSRB_CAL_WORDS; k = k + 1) begin
                if (i_wr && (i_waddr == k[1:0])) begin
                    mem_q[k] <= i_wdata;
                end
            end
            o_rdata <= mem_q[i_raddr];
        end
    end

endmodule

// File: src/csrb_core_regs.v
`timescale 1ns/1ps
`include "csrb_defs.vh"

// Functional notes
// - stack pointer increments before each push
// - stack pointer resets to 07h, first push 08h
// - high register low bits extend pointer to 11
// - data pointer is one 24-bit register at three byte addresses
// - pointer increment carries from high into page
// - status word flag bit positions as documented
// - two bank bits select register bank 0-3
// - power control bit layout as documented
// - unmapped addresses store nothing, read undefined
// - only addresses ending 0h or 8h bit-addressable
// - calibration registers load factory values at reset
// - auxiliary register is multiply/divide operand, scratch
// - extended stack grows from ffh into 0100h
// - upper 128 addresses, direct addressing only
module csrb_core_regs (
    // clock and reset
    input wire I_CLK_SYS,
    input wire I_ARST_N,
    // direct register access
    input wire [7:0] I_SFR_ADDR,
    input wire I_SFR_WR,
    input wire I_SFR_RD,
    input wire [7:0] I_SFR_WDATA,
    output wire [7:0] O_SFR_RDATA,
    output reg O_SFR_HIT,
    // single-bit access
    input wire [7:0] I_BIT_ADDR,
    input wire I_BIT_WR,
    input wire I_BIT_RD,
    input wire I_BIT_WDATA,
    output reg O_BIT_RDATA,
    output reg O_BIT_HIT,
    // arithmetic unit
    input wire [7:0] I_ARITH_RESULT_REG,
    input wire I_FLAG_WE,
    input wire I_CARRY,
    input wire I_HALF_CARRY,
    input wire I_OVERFLOW,
    input wire I_MULDIV_WE,
    input wire [7:0] I_MULDIV_RESULT,
    output wire [7:0] O_AUX_ARITH,
    // status flags
    output wire O_CARRY_FLAG,
    output wire O_HALF_CARRY_FLAG,
    output wire O_USER_FLAG_0,
    output wire O_USER_FLAG_1,
    output wire O_OVERFLOW_FLAG,
    output wire O_PARITY_FLAG,
    output wire [1:0] O_BANK_SELECT,
    // stack
    input wire I_STACK_PUSH,
    input wire I_STACK_POP,
    input wire I_EXT_STACK_EN,
    output wire [10:0] O_STACK_ADDR,
    // data pointer
    input wire I_DATA_POINTER_INC,
    output wire [23:0] O_DATA_POINTER,
    // power control
    input wire I_WAKE,
    output wire O_BAUD_DOUBLER,
    output wire O_SERIAL_WAKE_IRQ_EN,
    output wire O_EXT_INT_WAKE_EN,
    output wire O_LATCH_STROBE_DISABLE,
    output wire O_GP_FLAG_1,
    output wire O_GP_FLAG_0,
    output wire O_POWERDOWN_ENABLE,
    output wire O_CORE_HALT_ENABLE
);

    ////////////////////////////////////////////////////////////////////
    function bit_addressable;
        input [7:0] adr;
        begin
            bit_addressable = adr[7] && (adr[2:0] == 3'h0);
        end
    endfunction

    function [7:0] put_bit;
        input [7:0] val;
        input [2:0] idx;
        input b;
        reg [7:0] mask;
        begin
            mask = 8'h01 << idx;
            put_bit = b ? (val | mask) : (val & ~mask);
        end
    endfunction

    function is_cal;
        input [7:0] adr;
        begin
            is_cal = (adr >= `CSRB_ADR_CAL_BASE) &&
                (adr < (`CSRB_ADR_CAL_BASE + 8'h04));
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    reg [7:0] status_q;
    reg [7:0] status_d;
    reg [7:0] aux_q;
    reg [7:0] aux_d;
    reg [7:0] power_q;
    reg [7:0] power_d;
    reg [23:0] dpair_q;
    reg [23:0] dpair_d;
    reg [7:0] rdata_q;
    reg [7:0] rdata_d;
    reg hit_d;
    reg sel_cal_q;
    reg bit_d;
    wire direct_ok;
    wire wr_ok;
    wire [7:0] bit_byte;
    wire [2:0] bit_idx;
    wire bit_wr_status;
    wire bit_wr_aux;
    wire [7:0] stack_low;
    wire [7:0] stack_high;
    wire [7:0] cal_rdata;
    wire [1:0] cal_off;
    wire [7:0] cal_diff;

    // only the upper half of direct space belongs here
    assign direct_ok = I_SFR_ADDR[7];
    assign wr_ok = I_SFR_WR && direct_ok;
    assign bit_byte = {I_BIT_ADDR[7:3], 3'h0};
    assign bit_idx = I_BIT_ADDR[2:0];
    assign bit_wr_status = I_BIT_WR && bit_addressable(bit_byte) &&
        (bit_byte == `CSRB_ADR_STATUS_WORD);
    assign bit_wr_aux = I_BIT_WR && bit_addressable(bit_byte) &&
        (bit_byte == `CSRB_ADR_AUX_ARITH);
    assign cal_diff = I_SFR_ADDR - `CSRB_ADR_CAL_BASE;
    assign cal_off = cal_diff[1:0];

    ////////////////////////////////////////////////////////////////////
    csrb_stack_unit u_stack (
        .i_clk(I_CLK_SYS),
        .i_arst_n(I_ARST_N),
        .i_push(I_STACK_PUSH),
        .i_pop(I_STACK_POP),
        .i_ext_en(I_EXT_STACK_EN),
        .i_wr_low(wr_ok && (I_SFR_ADDR == `CSRB_ADR_STACK_POINTER)),
        .i_wr_high(wr_ok && (I_SFR_ADDR == `CSRB_ADR_STACK_POINTER_HIGH)),
        .i_wdata(I_SFR_WDATA),
        .o_low(stack_low),
        .o_high(stack_high),
        .o_addr(O_STACK_ADDR)
    );

    csrb_cal_mem u_cal (
        .i_clk(I_CLK_SYS),
        .i_arst_n(I_ARST_N),
        .i_wr(wr_ok && is_cal(I_SFR_ADDR)),
        .i_waddr(cal_off),
        .i_wdata(I_SFR_WDATA),
        .i_raddr(cal_off),
        .o_rdata(cal_rdata)
    );

    ////////////////////////////////////////////////////////////////////
    // alu flag updates win over a software write in the same cycle
    always @* begin
        status_d = status_q;
        if (wr_ok && (I_SFR_ADDR == `CSRB_ADR_STATUS_WORD)) begin
            status_d = I_SFR_WDATA;
        end else if (bit_wr_status) begin
            status_d = put_bit(status_q, bit_idx, I_BIT_WDATA);
        end
        if (I_FLAG_WE) begin
            status_d[`CSRB_STW_CARRY] = I_CARRY;
            status_d[`CSRB_STW_HALF_CARRY] = I_HALF_CARRY;
            status_d[`CSRB_STW_OVERFLOW] = I_OVERFLOW;
        end
        status_d[`CSRB_STW_PARITY] = ^I_ARITH_RESULT_REG;
    end

    always @* begin
        aux_d = aux_q;
        if (wr_ok && (I_SFR_ADDR == `CSRB_ADR_AUX_ARITH)) begin
            aux_d = I_SFR_WDATA;
        end else if (bit_wr_aux) begin
            aux_d = put_bit(aux_q, bit_idx, I_BIT_WDATA);
        end
        if (I_MULDIV_WE) begin
            aux_d = I_MULDIV_RESULT;
        end
    end

    // wake clears the low-power bits; a write in that cycle still wins
    always @* begin
        power_d = power_q;
        if (I_WAKE) begin
            power_d[`CSRB_PWR_POWERDOWN] = 1'b0;
            power_d[`CSRB_PWR_HALT] = 1'b0;
        end
        if (wr_ok && (I_SFR_ADDR == `CSRB_ADR_POWER_CONTROL)) begin
            power_d = I_SFR_WDATA;
        end
    end

    always @* begin
        dpair_d = dpair_q;
        if (I_DATA_POINTER_INC) begin
            dpair_d = dpair_q + 24'h000001;
        end else if (wr_ok) begin
            if (I_SFR_ADDR == `CSRB_ADR_DATA_POINTER_LOW) begin
                dpair_d[7:0] = I_SFR_WDATA;
            end else if (I_SFR_ADDR == `CSRB_ADR_DATA_POINTER_HIGH) begin
                dpair_d[15:8] = I_SFR_WDATA;
            end else if (I_SFR_ADDR == `CSRB_ADR_DATA_POINTER_PAGE) begin
                dpair_d[23:16] = I_SFR_WDATA;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // unmapped locations return zero and no hit
    always @* begin
        rdata_d = 8'h00;
        hit_d = 1'b1;
        if (!direct_ok) begin
            hit_d = 1'b0;
        end else if (I_SFR_ADDR == `CSRB_ADR_POWER_CONTROL) begin
            rdata_d = power_q;
        end else if (I_SFR_ADDR == `CSRB_ADR_STACK_POINTER) begin
            rdata_d = stack_low;
        end else if (I_SFR_ADDR == `CSRB_ADR_STACK_POINTER_HIGH) begin
            rdata_d = stack_high;
        end else if (I_SFR_ADDR == `CSRB_ADR_DATA_POINTER_LOW) begin
            rdata_d = dpair_q[7:0];
        end else if (I_SFR_ADDR == `CSRB_ADR_DATA_POINTER_HIGH) begin
            rdata_d = dpair_q[15:8];
        end else if (I_SFR_ADDR == `CSRB_ADR_DATA_POINTER_PAGE) begin
            rdata_d = dpair_q[23:16];
        end else if (I_SFR_ADDR == `CSRB_ADR_STATUS_WORD) begin
            rdata_d = status_q;
        end else if (I_SFR_ADDR == `CSRB_ADR_AUX_ARITH) begin
            rdata_d = aux_q;
        end else if (is_cal(I_SFR_ADDR)) begin
            rdata_d = 8'h00;
        end else begin
            hit_d = 1'b0;
        end
    end

    always @* begin
        bit_d = 1'b0;
        if (bit_byte == `CSRB_ADR_STATUS_WORD) begin
            bit_d = status_q[bit_idx];
        end else if (bit_byte == `CSRB_ADR_AUX_ARITH) begin
            bit_d = aux_q[bit_idx];
        end
    end

    ////////////////////////////////////////////////////////////////////
    always @(posedge I_CLK_SYS or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            status_q <= `CSRB_RST_STATUS_WORD;
            aux_q <= `CSRB_RST_AUX_ARITH;
            power_q <= `CSRB_RST_POWER_CONTROL;
            dpair_q <= {3{`CSRB_RST_DATA_POINTER}};
            rdata_q <= 8'h00;
            O_SFR_HIT <= 1'b0;
            sel_cal_q <= 1'b0;
            O_BIT_RDATA <= 1'b0;
            O_BIT_HIT <= 1'b0;
        end else begin
            status_q <= status_d;
            aux_q <= aux_d;
            power_q <= power_d;
            dpair_q <= dpair_d;
            rdata_q <= I_SFR_RD ? rdata_d : 8'h00;
            O_SFR_HIT <= I_SFR_RD && hit_d;
            sel_cal_q <= I_SFR_RD && direct_ok && is_cal(I_SFR_ADDR);
            O_BIT_RDATA <= I_BIT_RD ? bit_d : 1'b0;
            O_BIT_HIT <= I_BIT_RD && bit_addressable(bit_byte) &&
                ((bit_byte == `CSRB_ADR_STATUS_WORD) ||
                (bit_byte == `CSRB_ADR_AUX_ARITH));
        end
    end

    // calibration memory already registers its read data
    assign O_SFR_RDATA = sel_cal_q ? cal_rdata : rdata_q;

    ////////////////////////////////////////////////////////////////////
    assign O_AUX_ARITH = aux_q;
    assign O_CARRY_FLAG = status_q[`CSRB_STW_CARRY];
    assign O_HALF_CARRY_FLAG = status_q[`CSRB_STW_HALF_CARRY];
    assign O_USER_FLAG_0 = status_q[`CSRB_STW_USER_0];
    assign O_USER_FLAG_1 = status_q[`CSRB_STW_USER_1];
    assign O_OVERFLOW_FLAG = status_q[`CSRB_STW_OVERFLOW];
    assign O_PARITY_FLAG = status_q[`CSRB_STW_PARITY];
    assign O_BANK_SELECT =
        status_q[`CSRB_STW_BANK_HI:`CSRB_STW_BANK_LO];
    assign O_DATA_POINTER = dpair_q;
    assign O_BAUD_DOUBLER = power_q[`CSRB_PWR_BAUD_DOUBLER];
    assign O_SERIAL_WAKE_IRQ_EN = power_q[`CSRB_PWR_SERIAL_WAKE];
    assign O_EXT_INT_WAKE_EN = power_q[`CSRB_PWR_EXT_INT_WAKE];
    assign O_LATCH_STROBE_DISABLE = power_q[`CSRB_PWR_LATCH_OFF];
    assign O_GP_FLAG_1 = power_q[`CSRB_PWR_GP_1];
    assign O_GP_FLAG_0 = power_q[`CSRB_PWR_GP_0];
    assign O_POWERDOWN_ENABLE = power_q[`CSRB_PWR_POWERDOWN];
    assign O_CORE_HALT_ENABLE = power_q[`CSRB_PWR_HALT];

endmodule

// File: src/csrb_defs.vh
`ifndef CSRB_DEFS_VH
`define CSRB_DEFS_VH

// direct addresses in the special register space
`define CSRB_ADR_POWER_CONTROL 8'h87
`define CSRB_ADR_STACK_POINTER 8'h81
`define CSRB_ADR_STACK_POINTER_HIGH 8'hb7
`define CSRB_ADR_DATA_POINTER_LOW 8'h82
`define CSRB_ADR_DATA_POINTER_HIGH 8'h83
`define CSRB_ADR_DATA_POINTER_PAGE 8'h84
`define CSRB_ADR_STATUS_WORD 8'hd0
`define CSRB_ADR_AUX_ARITH 8'hf0
`define CSRB_ADR_CAL_BASE 8'hf1
`define CSRB_CAL_WORDS 4

// reset values
`define CSRB_RST_POWER_CONTROL 8'h00
`define CSRB_RST_STATUS_WORD 8'h00
`define CSRB_RST_STACK_POINTER 8'h07
`define CSRB_RST_STACK_POINTER_HIGH 8'h00
`define CSRB_RST_DATA_POINTER 8'h00
`define CSRB_RST_AUX_ARITH 8'h00
`define CSRB_CAL_FACTORY_0 8'h5a
`define CSRB_CAL_FACTORY_1 8'h3c
`define CSRB_CAL_FACTORY_2 8'ha5
`define CSRB_CAL_FACTORY_3 8'hc3

// status word fields
`define CSRB_STW_CARRY 7
`define CSRB_STW_HALF_CARRY 6
`define CSRB_STW_USER_0 5
`define CSRB_STW_BANK_HI 4
`define CSRB_STW_BANK_LO 3
`define CSRB_STW_OVERFLOW 2
`define CSRB_STW_USER_1 1
`define CSRB_STW_PARITY 0

// power control fields
`define CSRB_PWR_BAUD_DOUBLER 7
`define CSRB_PWR_SERIAL_WAKE 6
`define CSRB_PWR_EXT_INT_WAKE 5
`define CSRB_PWR_LATCH_OFF 4
`define CSRB_PWR_GP_1 3
`define CSRB_PWR_GP_0 2
`define CSRB_PWR_POWERDOWN 1
`define CSRB_PWR_HALT 0

// stack pointer high: only these low bits extend the pointer
`define CSRB_STACK_EXT_BITS 3

`endif

// File: src/csrb_stack_unit.v
`timescale 1ns/1ps
`include "csrb_defs.vh"

module csrb_stack_unit (
    // clock and reset
    input wire i_clk,
    input wire i_arst_n,
    // stack operations
    input wire i_push,
    input wire i_pop,
    input wire i_ext_en,
    // register writes
    input wire i_wr_low,
    input wire i_wr_high,
    input wire [7:0] i_wdata,
    // state
    output reg [7:0] o_low,
    output reg [7:0] o_high,
    output wire [10:0] o_addr
);

    wire [10:0] cur_ptr;
    reg [10:0] step_ptr;
    reg [7:0] low_d;
    reg [7:0] high_d;

    assign cur_ptr = {o_high[`CSRB_STACK_EXT_BITS-1:0], o_low};
    assign o_addr = cur_ptr;

    always @* begin
        step_ptr = cur_ptr;
        if (i_push) begin
            step_ptr = cur_ptr + 11'h001;
        end else if (i_pop) begin
            step_ptr = cur_ptr - 11'h001;
        end
        // plain mode keeps the upper bits, so ffh wraps to 00h
        if (!i_ext_en) begin
            step_ptr[10:8] = cur_ptr[10:8];
        end
    end

    // push and pop win over a direct write in the same cycle
    always @* begin
        low_d = o_low;
        high_d = o_high;
        if (i_push || i_pop) begin
            low_d = step_ptr[7:0];
            high_d = {o_high[7:3], step_ptr[10:8]};
        end else begin
            if (i_wr_low) begin
                low_d = i_wdata;
            end
            if (i_wr_high) begin
                high_d = i_wdata;
            end
        end
    end

    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_low <= `CSRB_RST_STACK_POINTER;
            o_high <= `CSRB_RST_STACK_POINTER_HIGH;
        end else begin
            o_low <= low_d;
            o_high <= high_d;
        end
    end

endmodule

// File: testbench/csrb_core_regs_sva.sv
`timescale 1ns/1ps
module csrb_chk (
    // clock and reset
    input wire I_CLK_SYS,
    input wire I_ARST_N,
    // direct bus
    input wire [7:0] I_SFR_ADDR,
    input wire I_SFR_WR,
    input wire I_SFR_RD,
    input wire [7:0] I_SFR_WDATA,
    input wire O_SFR_HIT,
    // arithmetic and status
    input wire [7:0] I_ARITH_RESULT_REG,
    input wire I_FLAG_WE,
    input wire I_MULDIV_WE,
    input wire [7:0] I_MULDIV_RESULT,
    input wire [7:0] O_AUX_ARITH,
    input wire O_CARRY_FLAG,
    input wire O_HALF_CARRY_FLAG,
    input wire O_USER_FLAG_0,
    input wire O_USER_FLAG_1,
    input wire O_OVERFLOW_FLAG,
    input wire O_PARITY_FLAG,
    input wire [1:0] O_BANK_SELECT,
    // stack and pointer
    input wire I_STACK_PUSH,
    input wire I_STACK_POP,
    input wire I_EXT_STACK_EN,
    input wire [10:0] O_STACK_ADDR,
    input wire I_DATA_POINTER_INC,
    input wire [23:0] O_DATA_POINTER
);
    default clocking @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_ARST_N);
    wire push_only = I_STACK_PUSH && !I_STACK_POP;
    wire pop_only = I_STACK_POP && !I_STACK_PUSH;
    // flag loads win over software, so leave those cycles out
    wire sw_stw = I_SFR_WR && I_SFR_ADDR == 8'hd0 && !I_FLAG_WE;
    ////////////////////////////////////////
    sequence s_stk_read;
        I_SFR_RD && I_SFR_ADDR == 8'h81 ##1 !I_SFR_RD;
    endsequence
    sequence s_hit_pulse;
        O_SFR_HIT ##1 !O_SFR_HIT;
    endsequence
    a_push_pre_inc: assert property (
        push_only && !I_EXT_STACK_EN |=> O_STACK_ADDR ==
        {$past(O_STACK_ADDR[10:8]), $past(O_STACK_ADDR[7:0]) + 8'h01})
        else $error("push did not step the low byte");
    a_ext_stack_grow: assert property (
        push_only && I_EXT_STACK_EN |=>
        O_STACK_ADDR == $past(O_STACK_ADDR) + 11'h001)
        else $error("extended push did not carry");
    a_ext_stack_pop: assert property (
        pop_only && I_EXT_STACK_EN |=>
        O_STACK_ADDR == $past(O_STACK_ADDR) - 11'h001)
        else $error("extended pop wrong");
    a_dpair_carry: assert property (
        I_DATA_POINTER_INC |=>
        O_DATA_POINTER == $past(O_DATA_POINTER) + 24'h000001)
        else $error("pointer increment wrong");
    a_parity_follow: assert property (
        1'b1 |=> O_PARITY_FLAG == ^$past(I_ARITH_RESULT_REG))
        else $error("parity does not follow arith reg");
    a_status_write: assert property (
        sw_stw |=> {O_CARRY_FLAG, O_HALF_CARRY_FLAG, O_USER_FLAG_0,
        O_BANK_SELECT, O_OVERFLOW_FLAG, O_USER_FLAG_1} ==
        $past(I_SFR_WDATA[7:1]))
        else $error("status write not reflected");
    a_muldiv_load: assert property (
        I_MULDIV_WE |=> O_AUX_ARITH == $past(I_MULDIV_RESULT))
        else $error("aux result not loaded");
    a_low_addr_ignored: assert property (
        I_SFR_RD && !I_SFR_ADDR[7] |=> !O_SFR_HIT)
        else $error("low address answered");
    a_read_one_cycle: assert property (
        s_stk_read |-> s_hit_pulse)
        else $error("read hit not a single pulse");
endmodule

bind csrb_core_regs csrb_chk i_csrb_chk (.I_CLK_SYS, .I_ARST_N,
    .I_SFR_ADDR, .I_SFR_WR, .I_SFR_RD, .I_SFR_WDATA, .O_SFR_HIT,
    .I_ARITH_RESULT_REG, .I_FLAG_WE, .I_MULDIV_WE, .I_MULDIV_RESULT,
    .O_AUX_ARITH, .O_CARRY_FLAG, .O_HALF_CARRY_FLAG, .O_USER_FLAG_0,
    .O_USER_FLAG_1, .O_OVERFLOW_FLAG, .O_PARITY_FLAG, .O_BANK_SELECT,
    .I_STACK_PUSH, .I_STACK_POP, .I_EXT_STACK_EN, .O_STACK_ADDR,
    .I_DATA_POINTER_INC, .O_DATA_POINTER);

// File: testbench/csrb_core_regs_tb_top.sv
`timescale 1ns/1ps
`include "csrb_defs.vh"
module csrb_core_regs_tb_top;
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg [7:0] bit_addr = 8'h00;
    reg bit_wr = 1'b0;
    reg bit_rd = 1'b0;
    reg bit_wdata = 1'b0;
    reg [7:0] arith_reg = 8'h00;
    reg flag_we = 1'b0;
    reg carry = 1'b0;
    reg half = 1'b0;
    reg ovf = 1'b0;
    reg md_we = 1'b0;
    reg [7:0] md_res = 8'h00;
    reg push = 1'b0;
    reg pop = 1'b0;
    reg ext = 1'b0;
    reg inc = 1'b0;
    reg wake = 1'b0;
    reg [7:0] d;
    reg h;
    integer i;
    integer n_errors = 0;
    integer total_checks = 0;
    wire [7:0] addr, wdata, rdata, aux, pw;
    wire wr, rd, hit, bit_rdata, bit_hit, cflag, hc, u0, u1, oflag, par;
    wire [1:0] bank;
    wire [10:0] stk;
    wire [23:0] dp;

    initial forever #12.5 clk = ~clk;

    csrb_core_regs i_csrb_core_regs (
        .I_CLK_SYS(clk), .I_ARST_N(rst_n),
        .I_SFR_ADDR(addr), .I_SFR_WR(wr), .I_SFR_RD(rd),
        .I_SFR_WDATA(wdata), .O_SFR_RDATA(rdata), .O_SFR_HIT(hit),
        .I_BIT_ADDR(bit_addr), .I_BIT_WR(bit_wr), .I_BIT_RD(bit_rd),
        .I_BIT_WDATA(bit_wdata), .O_BIT_RDATA(bit_rdata),
        .O_BIT_HIT(bit_hit), .I_ARITH_RESULT_REG(arith_reg),
        .I_FLAG_WE(flag_we),
        .I_CARRY(carry), .I_HALF_CARRY(half), .I_OVERFLOW(ovf),
        .I_MULDIV_WE(md_we), .I_MULDIV_RESULT(md_res), .O_AUX_ARITH(aux),
        .O_CARRY_FLAG(cflag), .O_HALF_CARRY_FLAG(hc), .O_USER_FLAG_0(u0),
        .O_USER_FLAG_1(u1), .O_OVERFLOW_FLAG(oflag), .O_PARITY_FLAG(par),
        .O_BANK_SELECT(bank), .I_STACK_PUSH(push), .I_STACK_POP(pop),
        .I_EXT_STACK_EN(ext), .O_STACK_ADDR(stk),
        .I_DATA_POINTER_INC(inc),
        .O_DATA_POINTER(dp), .I_WAKE(wake), .O_BAUD_DOUBLER(pw[7]),
        .O_SERIAL_WAKE_IRQ_EN(pw[6]), .O_EXT_INT_WAKE_EN(pw[5]),
        .O_LATCH_STROBE_DISABLE(pw[4]), .O_GP_FLAG_1(pw[3]),
        .O_GP_FLAG_0(pw[2]), .O_POWERDOWN_ENABLE(pw[1]),
        .O_CORE_HALT_ENABLE(pw[0]));

    csrb_cpu_model i_csrb_cpu_model (.i_clk(clk), .o_addr(addr),
        .o_wr(wr), .o_rd(rd), .o_wdata(wdata), .i_rdata(rdata),
        .i_hit(hit));
    ////////////////////////////////////////
    task chk(input [23:0] got, input [23:0] exp);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task step;
        @(negedge clk);
    endtask
    task rdchk(input [7:0] a, input [7:0] e);
        i_csrb_cpu_model.rd(a, d, h);
        chk(d, e);
        chk(h, 1'b1);
    endtask
    task end_sim;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task sp_pulse(input up);
        step;
        push = up;
        pop = ~up;
        step;
        push = 1'b0;
        pop = 1'b0;
    endtask
    task t_reset;
        chk(stk, 11'h007);
        chk(dp, 24'h000000);
        rdchk(8'h81, `CSRB_RST_STACK_POINTER);
        rdchk(8'hd0, 8'h00);
        rdchk(8'h87, 8'h00);
        rdchk(8'hf1, `CSRB_CAL_FACTORY_0);
        rdchk(8'hf2, `CSRB_CAL_FACTORY_1);
        rdchk(8'hf3, `CSRB_CAL_FACTORY_2);
        rdchk(8'hf4, `CSRB_CAL_FACTORY_3);
        i_csrb_cpu_model.wr(8'hf3, 8'h77);
        rdchk(8'hf3, 8'h77);
    endtask
    task t_stack;
        sp_pulse(1'b1);
        chk(stk, 11'h008);
        rdchk(8'h81, 8'h08);
        i_csrb_cpu_model.wr(8'h81, 8'hff);
        sp_pulse(1'b1);
        chk(stk, 11'h000);
        ext = 1'b1;
        i_csrb_cpu_model.wr(8'h81, 8'hff);
        sp_pulse(1'b1);
        chk(stk, 11'h100);
        i_csrb_cpu_model.wr(8'hb7, 8'hf5);
        chk(stk, 11'h500);
        sp_pulse(1'b0);
        chk(stk, 11'h4ff);
        ext = 1'b0;
    endtask
    task t_data_pointer_pair;
        i_csrb_cpu_model.wr(8'h82, 8'hfe);
        i_csrb_cpu_model.wr(8'h83, 8'hff);
        i_csrb_cpu_model.wr(8'h84, 8'h12);
        inc = 1'b1;
        step;
        step;
        inc = 1'b0;
        chk(dp, 24'h130000);
        rdchk(8'h84, 8'h13);
        rdchk(8'h82, 8'h00);
    endtask
    task t_status;
        for (i = 0; i < 4; i = i + 1) begin
            i_csrb_cpu_model.wr(8'hd0, {3'h0, i[1:0], 3'h0});
            chk(bank, i[1:0]);
        end
        i_csrb_cpu_model.wr(8'hd0, 8'ha7);
        chk({cflag, hc, u0, bank, oflag, u1, par}, 8'ha6);
        arith_reg = 8'h07;
        step;
        chk(par, 1'b1);
        carry = 1'b1;
        half = 1'b1;
        flag_we = 1'b1;
        step;
        flag_we = 1'b0;
        chk({cflag, hc, oflag}, 3'h6);
        bit_addr = 8'hd1;
        bit_wr = 1'b1;
        step;
        bit_wr = 1'b0;
        chk(u1, 1'b0);
        bit_addr = 8'hd5;
        bit_rd = 1'b1;
        step;
        bit_rd = 1'b0;
        chk({bit_hit, bit_rdata}, 2'h3);
    endtask
    task t_power;
        i_csrb_cpu_model.wr(8'h87, 8'hb7);
        chk(pw, 8'hb7);
        wake = 1'b1;
        step;
        wake = 1'b0;
        chk(pw, 8'hb4);
        rdchk(8'h87, 8'hb4);
    endtask
    task t_aux;
        i_csrb_cpu_model.wr(8'hf0, 8'h3c);
        rdchk(8'hf0, 8'h3c);
        md_res = 8'h99;
        md_we = 1'b1;
        step;
        md_we = 1'b0;
        chk(aux, 8'h99);
        bit_addr = 8'hf6;
        bit_wdata = 1'b1;
        bit_wr = 1'b1;
        step;
        bit_wr = 1'b0;
        chk(aux, 8'hd9);
    endtask
    task t_unmapped;
        i_csrb_cpu_model.wr(8'hc1, 8'h55);
        i_csrb_cpu_model.rd(8'hc1, d, h);
        chk(h, 1'b0);
        i_csrb_cpu_model.rd(8'h50, d, h);
        chk(h, 1'b0);
    endtask
    initial begin
        repeat (4) @(posedge clk);
        step;
        rst_n = 1'b1;
        t_reset;
        t_stack;
        t_data_pointer_pair;
        t_status;
        t_power;
        t_aux;
        t_unmapped;
        end_sim;
    end
    // whole run needs under a hundred cycles
    initial begin
        repeat (3000) @(posedge clk);
        n_errors = n_errors + 1;
        end_sim;
    end
endmodule

// File: testbench/csrb_cpu_model.sv
`timescale 1ns/1ps
module csrb_cpu_model (
    // clock
    input wire i_clk,
    // direct bus
    output reg [7:0] o_addr,
    output reg o_wr,
    output reg o_rd,
    output reg [7:0] o_wdata,
    input wire [7:0] i_rdata,
    input wire i_hit
);
    initial begin
        o_addr = 8'h00;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_wdata = 8'h00;
    end
    ////////////////////////////////////////
    // test locations and port registers are never addressed
    task wr(input [7:0] a, input [7:0] d);
        @(negedge i_clk);
        o_addr = a;
        o_wdata = d;
        o_wr = 1'b1;
        @(negedge i_clk);
        o_wr = 1'b0;
        // released data must not look still valid
        o_wdata = ~d;
    endtask
    task rd(input [7:0] a, output [7:0] d, output h);
        @(negedge i_clk);
        o_addr = a;
        o_rd = 1'b1;
        @(negedge i_clk);
        o_rd = 1'b0;
        o_addr = ~a;
        d = i_rdata;
        h = i_hit;
    endtask
endmodule
